// ===== core/swdt_params.svh
// timing and field constants for the system watchdog timer
// Function
// - expiry while enabled pulses system reset
// - led blinks while counting, steady otherwise
// - reset leaves the timer disabled
// - retrigger reloads counter with the factor
// - count decrements once per second
// - factors 1 to FF accepted
// - nonzero byte write enables timer
// - zero byte write disables timer
// - new factor applies at once, restarting the countdown
`ifndef SWDT_PARAMS_SVH
`define SWDT_PARAMS_SVH

// ----------------------------------------------------------------
// factor byte
// ----------------------------------------------------------------
`define SWDT_FACTOR_W 8
`define SWDT_FACTOR_OFF 8'h00
`define SWDT_FACTOR_ONE 8'h01
`define SWDT_FACTOR_MAX 8'hFF

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SWDT_UNIT_MS 1000
`define SWDT_CLK_PERIOD_NS 10
`define SWDT_TICK_CYC ((`SWDT_UNIT_MS * 1000000) / `SWDT_CLK_PERIOD_NS)
`define SWDT_TICK_W 27
`define SWDT_RST_PULSE_CYC 8
`define SWDT_PULSE_W 4

`endif

// ===== core/swdt_pkg.sv
// types shared by the system watchdog timer modules
`default_nettype none
`include "swdt_params.svh"

package swdt_pkg;
    // factor byte as written by software
    typedef logic [`SWDT_FACTOR_W-1:0] swdt_factor_t;

    // controller states, one-hot
    typedef enum logic [2:0] {
        SWDT_IDLE  = 3'h1,
        SWDT_COUNT = 3'h2,
        SWDT_RESET = 3'h4
    } swdt_state_e;
endpackage

`default_nettype wire

// ===== core/swdt_tick_gen.sv
// one-second prescaler for the system watchdog timer
`timescale 1ns/1ns
`default_nettype none
`include "swdt_params.svh"

module swdt_tick_gen #(
    parameter int unsigned TICK_CYC = `SWDT_TICK_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // controller side
    swdt_tick_if.gen tk
);
    import swdt_pkg::*;

    // ------------------------------------------------------------
    // prescaler counter
    // ------------------------------------------------------------
    logic [`SWDT_TICK_W-1:0] pre_ff; // cycles into the current second
    logic [`SWDT_TICK_W-1:0] nxt_pre;
    logic at_end;                    // last cycle of the second

    assign at_end = (pre_ff == `SWDT_TICK_W'(TICK_CYC - 1));

    // strobe is combinational so the controller sees it the same cycle
    assign tk.tick = tk.run && !tk.clr && at_end;

    // next prescaler value
    always_comb
    begin
        if (tk.clr || !tk.run)
        begin
            // a write restarts a full second, avoiding a short first unit
            nxt_pre = '0;
        end
        else if (at_end)
        begin
            nxt_pre = '0;
        end
        else
        begin
            nxt_pre = pre_ff + `SWDT_TICK_W'(1);
        end
    end

    // register only
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            pre_ff <= '0;
        end
        else
        begin
            pre_ff <= nxt_pre;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_tick_clr;
        @(posedge ref_clk) disable iff (rst)
        tk.clr |=> (pre_ff == '0) && !tk.tick;
    endproperty
    a_tick_clr: assert property (p_tick_clr)
        else $error("prescaler not cleared by factor write");

endmodule

`default_nettype wire

// ===== core/swdt_tick_if.sv
// tick request and strobe between controller and prescaler
`timescale 1ns/1ns
`default_nettype none

interface swdt_tick_if;
    logic clr;  // restart the one-second period
    logic run;  // prescaler counts only while set
    logic tick; // one-cycle strobe at period end

    modport ctrl (output clr, output run, input tick);
    modport gen (input clr, input run, output tick);
endinterface

`default_nettype wire

// ===== core/swdt_top.sv
// system watchdog timer: factor write port, countdown, reset pulse, led
`timescale 1ns/1ns
`default_nettype none
`include "swdt_params.svh"

module swdt_top #(
    parameter int unsigned TICK_CYC = `SWDT_TICK_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // factor write port, same clock domain
    input wire logic wr_stb,
    input wire swdt_pkg::swdt_factor_t wr_data,
    // system side
    output logic sys_rst_out,
    output logic led_out,
    output logic counting
);
    import swdt_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    swdt_state_e state_ff;  // controller state
    swdt_state_e nxt_state;
    swdt_factor_t cnt_ff;   // seconds left
    swdt_factor_t nxt_cnt;
    logic [`SWDT_PULSE_W-1:0] pulse_ff; // reset cycles left
    logic [`SWDT_PULSE_W-1:0] nxt_pulse;
    logic led_ff;           // blink phase
    logic nxt_led;

    swdt_tick_if tk ();

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    // any factor write restarts the second; counting gates it
    assign tk.clr = wr_stb;
    assign tk.run = (state_ff == SWDT_COUNT);

    swdt_tick_gen #(
        .TICK_CYC(TICK_CYC)
    ) u_tick (
        .ref_clk(ref_clk),
        .rst(rst),
        .tk(tk)
    );

    // ------------------------------------------------------------
    // controller next state
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_pulse = pulse_ff;
        unique case (state_ff)
            SWDT_IDLE, SWDT_COUNT:
            begin
                if (wr_stb && (wr_data == `SWDT_FACTOR_OFF))
                begin
                    // zero byte stops everything
                    nxt_state = SWDT_IDLE;
                end
                else if (wr_stb)
                begin
                    // enable or retrigger, any factor 01..FF
                    nxt_state = SWDT_COUNT;
                    nxt_cnt = wr_data;
                end
                else if ((state_ff == SWDT_COUNT) && tk.tick)
                begin
                    if (cnt_ff == `SWDT_FACTOR_ONE)
                    begin
                        // no retrigger in time: reset the system
                        nxt_state = SWDT_RESET;
                        nxt_pulse = `SWDT_PULSE_W'(`SWDT_RST_PULSE_CYC - 1);
                    end
                    else
                    begin
                        nxt_cnt = cnt_ff - `SWDT_FACTOR_W'(1);
                    end
                end
            end
            SWDT_RESET:
            begin
                // writes ignored: the system is going down anyway
                if (pulse_ff == '0)
                begin
                    nxt_state = SWDT_IDLE;
                end
                else
                begin
                    nxt_pulse = pulse_ff - `SWDT_PULSE_W'(1);
                end
            end
            default:
            begin
                nxt_state = SWDT_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // led next value
    // ------------------------------------------------------------
    // toggles once a second while counting, dark otherwise
    always_comb
    begin
        if (nxt_state != SWDT_COUNT)
        begin
            nxt_led = 1'b0;
        end
        else if ((state_ff == SWDT_COUNT) && tk.tick)
        begin
            nxt_led = !led_ff;
        end
        else
        begin
            nxt_led = led_ff;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            // come up disabled, unable to time out
            state_ff <= SWDT_IDLE;
            cnt_ff <= `SWDT_FACTOR_OFF;
            pulse_ff <= '0;
            led_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            pulse_ff <= nxt_pulse;
            led_ff <= nxt_led;
        end
    end

    // reset and counting decoded from the registered one-hot state, led straight from its register
    assign sys_rst_out = (state_ff == SWDT_RESET);
    assign led_out = led_ff;
    assign counting = (state_ff == SWDT_COUNT);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_expire;
        @(posedge ref_clk) disable iff (rst)
        (state_ff == SWDT_COUNT) && tk.tick && !wr_stb &&
        (cnt_ff == `SWDT_FACTOR_ONE) |=> sys_rst_out;
    endproperty
    a_expire: assert property (p_expire)
        else $error("no reset pulse on expiry");

    property p_led_off;
        @(posedge ref_clk) disable iff (rst)
        !counting |-> !led_out;
    endproperty
    a_led_off: assert property (p_led_off)
        else $error("led lit while not counting");

    property p_led_blink;
        @(posedge ref_clk) disable iff (rst)
        counting && tk.tick && !wr_stb && (cnt_ff > `SWDT_FACTOR_ONE)
        |=> led_out != $past(led_out);
    endproperty
    a_led_blink: assert property (p_led_blink)
        else $error("led did not toggle on tick");

    property p_idle_quiet;
        @(posedge ref_clk) disable iff (rst)
        !counting && !sys_rst_out && !wr_stb |=> !sys_rst_out && !counting;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("disabled timer started or reset");

    property p_load;
        @(posedge ref_clk) disable iff (rst)
        wr_stb && !sys_rst_out && (wr_data != `SWDT_FACTOR_OFF)
        |=> counting && (cnt_ff == $past(wr_data));
    endproperty
    a_load: assert property (p_load)
        else $error("factor not loaded on write");

    property p_dec;
        @(posedge ref_clk) disable iff (rst)
        counting && tk.tick && !wr_stb && (cnt_ff > `SWDT_FACTOR_ONE)
        |=> counting && (cnt_ff == $past(cnt_ff) - `SWDT_FACTOR_ONE);
    endproperty
    a_dec: assert property (p_dec)
        else $error("count not decremented on tick");

    property p_hold;
        @(posedge ref_clk) disable iff (rst)
        counting && !tk.tick && !wr_stb |=> cnt_ff == $past(cnt_ff);
    endproperty
    a_hold: assert property (p_hold)
        else $error("count moved without tick");

    property p_enable_byte;
        @(posedge ref_clk) disable iff (rst)
        counting |-> (cnt_ff >= `SWDT_FACTOR_ONE);
    endproperty
    a_enable_byte: assert property (p_enable_byte)
        else $error("counting with zero factor");

    property p_disable;
        @(posedge ref_clk) disable iff (rst)
        wr_stb && !sys_rst_out && (wr_data == `SWDT_FACTOR_OFF)
        |=> !counting ##1 !sys_rst_out;
    endproperty
    a_disable: assert property (p_disable)
        else $error("zero write did not disable");

    property p_pulse_len;
        @(posedge ref_clk) disable iff (rst)
        $rose(sys_rst_out) |-> sys_rst_out[*8] ##1 (!sys_rst_out && !counting);
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("reset pulse length wrong");

endmodule

`default_nettype wire

// ===== test/test_system_watchdog_timer.sv
// self-checking bench for the system watchdog timer
`timescale 1ns/1ns
`default_nettype none
`include "swdt_params.svh"

module test_system_watchdog_timer;
    import swdt_pkg::*;

    // ------------------------------------------------------------
    // signals and bookkeeping
    // ------------------------------------------------------------
    localparam int TK = 4; // short second keeps runs brief
    localparam int PW = `SWDT_RST_PULSE_CYC;
    typedef struct {int at; int tg;} swdt_note_s; // expiry cycle, blinks
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic wr_stb = 1'b0;
    swdt_factor_t wr_data = 8'h00;
    logic sys_rst_out;
    logic led_out;
    logic counting;
    int n_fail = 0;
    int tests_run = 0;
    int cyc = 0; // rising edges seen so far
    int seed = 56381;
    int hi = 0; // cycles the pulse has stood
    int tg = 0; // led changes since last write strobe, dropped writes included
    logic led_q = 1'b0;
    logic rst_q = 1'b0;
    swdt_note_s nt;
    swdt_note_s notes[$]; // at most one live expiry at a time

    swdt_top #(
        .TICK_CYC(TK)
    ) dut_u (
        .ref_clk(ref_clk),
        .rst(rst),
        .wr_stb(wr_stb),
        .wr_data(wr_data),
        .sys_rst_out(sys_rst_out),
        .led_out(led_out),
        .counting(counting)
    );

    // free running clock and edge counter
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    // one write; live writes replace the pending expiry note
    task automatic put(input swdt_factor_t f, input bit live);
        @(posedge ref_clk);
        #1;
        wr_stb = 1'b1;
        wr_data = f;
        if (live)
        begin
            notes.delete();
            if (f != 8'h00)
                notes.push_back('{cyc + 1 + f * TK, f - 1});
        end
        @(posedge ref_clk);
        #1;
        wr_stb = 1'b0;
        wr_data = swdt_factor_t'($random(seed)); // idle junk must be ignored
    endtask

    // bounded wait until no expiry is pending and the pulse is over
    task automatic wait_idle();
        int i;
        // look just after the edge, once the outputs have settled
        for (i = 0; i < 2000 && (notes.size() != 0 || sys_rst_out); i++)
        begin
            @(posedge ref_clk);
            #1;
        end
        repeat (2) @(posedge ref_clk);
        chk("idle reached", 1, i < 2000);
    endtask

    task automatic give_verdict();
        if (n_fail == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // output watcher: pulses are matched against the oldest note
    // ------------------------------------------------------------
    always @(negedge ref_clk)
    begin
        // blinks counted only while counting, so the expiry edge is skipped
        if (wr_stb)
            tg = 0;
        else if (counting && led_out !== led_q)
            tg++;
        led_q = led_out;
        if (sys_rst_out && !rst_q)
        begin
            if (notes.size() == 0)
                chk("unexpected reset pulse", 0, 1);
            else
            begin
                nt = notes.pop_front();
                chk("pulse start cycle", nt.at, cyc);
                chk("blinks before expiry", nt.tg, tg);
                chk("counting at expiry", 0, counting);
            end
        end
        if (!sys_rst_out && rst_q)
            chk("pulse length", PW, hi);
        hi = sys_rst_out ? hi + 1 : 0;
        rst_q = sys_rst_out;
    end

    // hang guard, far beyond the planned run
    initial
    begin
        #400000;
        n_fail++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial
    begin
        swdt_factor_t f;
        repeat (2) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        chk("counting after reset", 0, counting);
        chk("led after reset", 0, led_out);
        repeat (40) @(posedge ref_clk);
        // smallest factor expires after one second
        put(8'h01, 1'b1);
        chk("counting after enable", 1, counting);
        wait_idle();
        // retriggers faster than a second hold off the tick
        repeat (6) put(8'h03, 1'b1);
        wait_idle();
        // a new factor replaces the running countdown at once
        put(8'h05, 1'b1);
        put(8'h02, 1'b1);
        wait_idle();
        // zero write stops everything
        put(8'h03, 1'b1);
        repeat (9) @(posedge ref_clk);
        put(8'h00, 1'b1);
        chk("counting after disable", 0, counting);
        chk("led after disable", 0, led_out);
        repeat (40) @(posedge ref_clk);
        // writes during the pulse are dropped, timer ends idle
        put(8'h01, 1'b1);
        for (int i = 0; i < 20 && !sys_rst_out; i++)
        begin
            @(posedge ref_clk);
            #1;
        end
        put(8'h07, 1'b0);
        wait_idle();
        chk("idle after pulse", 0, counting);
        repeat (40) @(posedge ref_clk);
        // largest factor, then random ones
        for (int i = 0; i < 5; i++)
        begin
            f = (i == 0) ? 8'hFF : swdt_factor_t'($random(seed));
            if (f == 8'h00)
                f = 8'h01;
            put(f, 1'b1);
            wait_idle();
        end
        // reset in mid count leaves the timer disabled
        put(8'h02, 1'b1);
        repeat (3) @(posedge ref_clk);
        #1;
        rst = 1'b1;
        notes.delete();
        @(posedge ref_clk);
        #1;
        rst = 1'b0;
        chk("counting after mid reset", 0, counting);
        repeat (40) @(posedge ref_clk);
        chk("counting long after mid reset", 0, counting);
        chk("led long after mid reset", 0, led_out);
        give_verdict();
    end
endmodule

`default_nettype wire
